// ### hdl/usb_host_list_pointer_regs_params.svh
// offsets, field positions and reset values of the list pointer registers
`ifndef USB_HOST_LIST_POINTER_REGS_PARAMS_SVH
`define USB_HOST_LIST_POINTER_REGS_PARAMS_SVH

`define LPR_ADDR_W            8
`define LPR_OFS_COMM_AREA     8'h18
`define LPR_OFS_PERIODIC_CUR  8'h1C
`define LPR_OFS_CONTROL_HEAD  8'h20

`define LPR_COMM_AREA_LSB     8
`define LPR_PERIODIC_LSB      4

`define LPR_COMM_AREA_RESET   32'h0000_0000
`define LPR_PERIODIC_RESET    32'h0000_0000
`define LPR_CONTROL_RESET     32'h0000_0000
`define LPR_UNMAPPED_DATA     32'h0000_0000

`endif

// ### hdl/usb_host_list_pointer_regs_pkg.sv
// types carried between the register port, the list engine and this block
package usb_host_list_pointer_regs_pkg;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  byteEn;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } reg_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } desc_update_t;

    typedef struct packed {
        logic [31:0] commAreaBase;
        logic [31:0] periodicCurrent;
        logic [31:0] controlListHead;
    } list_ptrs_t;

endpackage : usb_host_list_pointer_regs_pkg

// ### hdl/usb_host_list_pointer_regs.sv
// communication area base, current periodic descriptor and control list head registers
// Operation
// - read/write comm area register at 0x18
// - bits 31:8 writable, readable, reset zero
// - bits 7:0 always read zero
// - comm area shared by controller and driver
// - periodic descriptor pointer register at 0x1C
// - pointer heads periodic list this frame
// - controller updates pointer after each descriptor
// - pointer read-only, bits 31:4, reset zero
// - control list head register at 0x20
`timescale 1ns/100ps
`include "usb_host_list_pointer_regs_params.svh"

module usb_host_list_pointer_regs (
    input  wire logic                                        ref_clk,
    input  wire logic                                        sys_rst,
    input  wire logic                                        swReset,
    input  wire usb_host_list_pointer_regs_pkg::reg_req_t    regReq,
    output      usb_host_list_pointer_regs_pkg::reg_rsp_t    regRsp,
    input  wire usb_host_list_pointer_regs_pkg::desc_update_t descUpdate,
    output      usb_host_list_pointer_regs_pkg::list_ptrs_t  listPtrs
);

    // byte lanes on the register port
    localparam int unsigned LaneCnt = 4;
    localparam int unsigned LaneW   = 8;

    // ones from the given bit position upward, zeros below it
    function automatic logic [31:0] fieldMask(
        input int unsigned lsb);
        logic [31:0] res;
        res = 32'h0000_0000;
        for (int i = 0; i < 32; i++) begin
            if (i >= lsb) begin
                res[i] = 1'b1;
            end
        end
        return res;
    endfunction : fieldMask

    // one enable bit per data bit
    function automatic logic [31:0] laneMask(
        input logic [3:0] byteEn);
        logic [31:0] res;
        res = 32'h0000_0000;
        for (int i = 0; i < LaneCnt; i++) begin
            res[LaneW*i +: LaneW] = {LaneW{byteEn[i]}};
        end
        return res;
    endfunction : laneMask

    // byte-lane merge of a write into a stored word, limited to the writable bits
    function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                               input logic [31:0] newVal,
                                               input logic [3:0]  byteEn,
                                               input logic [31:0] wrMask);
        logic [31:0] keep;
        logic [31:0] res;
        keep = laneMask(byteEn) & wrMask;
        res = (newVal & keep) | (oldVal & ~keep);
        return res;
    endfunction : mergeBytes

    // byte enables of a write that lands on this register, none otherwise
    function automatic logic [3:0] laneSelect(input logic       write,
                                              input logic       hit,
                                              input logic [3:0] byteEn);
        return (write && hit) ? byteEn : 4'h0;
    endfunction : laneSelect

    // one-hot register select for an offset; zero for unmapped offsets
    function automatic logic [2:0] regSelect(
        input logic [7:0] addr);
        logic [2:0] sel;
        sel = 3'h0;
        unique case (addr)
            `LPR_OFS_COMM_AREA: begin
                sel = 3'h1;
            end
            `LPR_OFS_PERIODIC_CUR: begin
                sel = 3'h2;
            end
            `LPR_OFS_CONTROL_HEAD: begin
                sel = 3'h4;
            end
            default: begin
                sel = 3'h0;
            end
        endcase
        return sel;
    endfunction : regSelect

    // stored word of the selected register
    function automatic logic [31:0] readSelect(input logic [2:0]  sel,
                                               input logic [31:0] commVal,
                                               input logic [31:0] periodicVal,
                                               input logic [31:0] controlVal);
        logic [31:0] res;
        res = `LPR_UNMAPPED_DATA;
        unique case (sel)
            3'h1: begin
                res = commVal;
            end
            3'h2: begin
                res = periodicVal;
            end
            3'h4: begin
                res = controlVal;
            end
            default: begin
                res = `LPR_UNMAPPED_DATA;
            end
        endcase
        return res;
    endfunction : readSelect

    // bits of the selected register that may read as anything but zero
    function automatic logic [31:0] readMask(
        input logic [2:0] sel);
        logic [31:0] res;
        res = 32'h0000_0000;
        unique case (sel)
            3'h1: begin
                res = fieldMask(`LPR_COMM_AREA_LSB);
            end
            3'h2: begin
                res = fieldMask(`LPR_PERIODIC_LSB);
            end
            3'h4: begin
                res = 32'hFFFF_FFFF;
            end
            default: begin
                res = 32'h0000_0000;
            end
        endcase
        return res;
    endfunction : readMask

    // stored bits of each address field; the low bits never reach a flop
    localparam logic [31:0] commMask     = fieldMask(`LPR_COMM_AREA_LSB);
    localparam logic [31:0] periodicMask = fieldMask(`LPR_PERIODIC_LSB);

    // bits a bus write may change; none for the engine-owned pointer
    localparam logic [31:0] commWrMask     = commMask;
    localparam logic [31:0] periodicWrMask = 32'h0000_0000;
    localparam logic [31:0] controlWrMask  = 32'hFFFF_FFFF;

    // communication area base
    logic [31:0] commArea_q;
    logic [31:0] commArea_d;

    // current periodic descriptor
    logic [31:0] periodic_q;
    logic [31:0] periodic_d;

    // control list head
    logic [31:0] controlHead_q;
    logic [31:0] controlHead_d;

    // bus answer
    logic        rspAck_q;
    logic        rspAck_d;
    logic [31:0] rspData_q;
    logic [31:0] rspData_d;

    // decode
    logic [2:0]  regSel;
    logic        hitComm;
    logic        hitPeriodic;
    logic        hitControl;

    // request qualifiers
    logic        busWrite;
    logic        busRead;
    logic        busAccess;

    // register clear
    logic        clearAll;

    // list engine load
    logic        engineLoad;
    logic [31:0] engineAddr;

    // byte lanes each write may touch
    logic [3:0]  commLaneWr;
    logic [3:0]  periodicLaneWr;
    logic [3:0]  controlLaneWr;

    // word as software reads it back
    logic [31:0] readVal;

    // address decode, shared by the write and the read path
    // a single select keeps the two paths from disagreeing on an offset
    assign regSel      = regSelect(regReq.addr);
    assign hitComm     = regSel[0];
    assign hitPeriodic = regSel[1];
    assign hitControl  = regSel[2];

    // request qualifiers
    assign busWrite  = regReq.wr;
    assign busRead   = regReq.rd;
    assign busAccess = busWrite | busRead;

    // hardware and software reset clear the same three registers
    assign clearAll = sys_rst | swReset;

    // low descriptor address bits dropped before the flop
    // so the reserved bits can never read back as ones
    assign engineLoad = descUpdate.valid;
    assign engineAddr = descUpdate.addr & periodicMask;

    // lanes gated by the select, so a write elsewhere leaves the word alone
    assign commLaneWr     = laneSelect(busWrite, hitComm, regReq.byteEn);
    assign periodicLaneWr = laneSelect(busWrite, hitPeriodic, regReq.byteEn);
    assign controlLaneWr  = laneSelect(busWrite, hitControl, regReq.byteEn);

    // low eight bits never stored, so any write returns zeros there
    // the alignment probe of all ones reads back with the low byte cleared
    assign commArea_d = mergeBytes(commArea_q, regReq.wdata,
                                   commLaneWr, commWrMask);

    // only the list engine moves this pointer; bus writes fall through
    // writable mask of zero keeps a bus write from touching any bit
    assign periodic_d = engineLoad ? engineAddr
                                   : mergeBytes(periodic_q, regReq.wdata,
                                                periodicLaneWr, periodicWrMask);

    // full word stored, no field layout is imposed on the control head
    assign controlHead_d = mergeBytes(controlHead_q, regReq.wdata,
                                      controlLaneWr, controlWrMask);

    // unmapped offsets answer zero so probing software never hangs
    // reserved low bits masked again on the read path
    assign readVal = readSelect(regSel, commArea_q, periodic_q, controlHead_q)
                   & readMask(regSel);

    // read data is the value held before a same-cycle write
    assign rspData_d = busRead ? readVal : 32'h0000_0000;
    // every access is answered, mapped or not
    assign rspAck_d  = busAccess;

    // shared communication area base
    // either reset clears it; a same-cycle write loses
    always_ff @(posedge ref_clk) begin
        if (clearAll) begin
            commArea_q <= `LPR_COMM_AREA_RESET;
        end else begin
            commArea_q <= commArea_d;
        end
    end

    // current periodic descriptor, owned by the list engine
    // a reset wins over a same-cycle engine load
    always_ff @(posedge ref_clk) begin
        if (clearAll) begin
            periodic_q <= `LPR_PERIODIC_RESET;
        end else begin
            periodic_q <= periodic_d;
        end
    end

    // control list head
    // reset value zero, as no layout is given for this word
    always_ff @(posedge ref_clk) begin
        if (clearAll) begin
            controlHead_q <= `LPR_CONTROL_RESET;
        end else begin
            controlHead_q <= controlHead_d;
        end
    end

    // answer strobe
    // only the hardware reset clears it, so an access in flight still completes
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rspAck_q <= 1'b0;
        end else begin
            rspAck_q <= rspAck_d;
        end
    end

    // answer data
    // zero outside reads so a stale word never sits on the bus
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rspData_q <= 32'h0000_0000;
        end else begin
            rspData_q <= rspData_d;
        end
    end

    // answer straight from the flops
    assign regRsp.ack   = rspAck_q;
    assign regRsp.rdata = rspData_q;

    // engine reads the shared area base and the list heads straight from the flops
    assign listPtrs.commAreaBase    = commArea_q;
    assign listPtrs.periodicCurrent = periodic_q;
    assign listPtrs.controlListHead = controlHead_q;

endmodule : usb_host_list_pointer_regs

// ### verif/usb_host_list_pointer_regs_monitor.sv
// port assertions for the list pointer registers
`timescale 1ns/100ps
module usb_host_list_pointer_regs_monitor (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic swReset,
    input wire usb_host_list_pointer_regs_pkg::reg_req_t regReq,
    input wire usb_host_list_pointer_regs_pkg::reg_rsp_t regRsp,
    input wire usb_host_list_pointer_regs_pkg::desc_update_t descUpdate,
    input wire usb_host_list_pointer_regs_pkg::list_ptrs_t listPtrs
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // soft reset wins over a same-cycle load
    wire wrAll = regReq.wr && regReq.byteEn == 4'hF && !swReset;
    wire updOk = descUpdate.valid && !swReset;
    AST_ACK: assert property (regReq.rd || regReq.wr |=> regRsp.ack)
        else $error("no ack");
    AST_COMM_WR: assert property (wrAll && regReq.addr == 8'h18 |=>
        listPtrs.commAreaBase == {$past(regReq.wdata[31:8]), 8'h00}) else $error("comm write");
    AST_COMM_LOW: assert property (listPtrs.commAreaBase[7:0] == 8'h00)
        else $error("comm low bits");
    AST_PER_LOW: assert property (listPtrs.periodicCurrent[3:0] == 4'h0)
        else $error("periodic low bits");
    AST_PER_UPD: assert property (updOk |=>
        listPtrs.periodicCurrent == {$past(descUpdate.addr[31:4]), 4'h0}) else $error("update");
    AST_PER_RO: assert property (!descUpdate.valid && !swReset |=>
        $stable(listPtrs.periodicCurrent)) else $error("periodic moved");
    AST_CTL_WR: assert property (wrAll && regReq.addr == 8'h20 |=>
        listPtrs.controlListHead == $past(regReq.wdata)) else $error("control write");
    AST_PER_RD: assert property (regReq.rd && regReq.addr == 8'h1C |=>
        regRsp.rdata == $past(listPtrs.periodicCurrent)) else $error("periodic read");
    AST_SW_CLR: assert property (swReset |=> listPtrs.commAreaBase == 32'h0000_0000 &&
        listPtrs.controlListHead == 32'h0000_0000) else $error("soft reset");
endmodule : usb_host_list_pointer_regs_monitor
bind usb_host_list_pointer_regs usb_host_list_pointer_regs_monitor u_mon (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .swReset(swReset), .regReq(regReq), .regRsp(regRsp),
    .descUpdate(descUpdate), .listPtrs(listPtrs));

// ### verif/tb_top.sv
// self-checking bench for the list pointer registers
`timescale 1ns/100ps
module tb_top;
    logic ref_clk = 0, sys_rst = 1;
    logic swRst = 0;
    usb_host_list_pointer_regs_pkg::reg_req_t req = '0;
    usb_host_list_pointer_regs_pkg::reg_rsp_t rsp;
    usb_host_list_pointer_regs_pkg::desc_update_t upd = '0;
    usb_host_list_pointer_regs_pkg::list_ptrs_t ptrs;
    int errorCnt = 0, totalChecks = 0;
    logic [31:0] r;
    usb_host_list_pointer_regs u_usb_host_list_pointer_regs (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .swReset(swRst), .regReq(req), .regRsp(rsp),
        .descUpdate(upd), .listPtrs(ptrs));
    initial forever #2 ref_clk = ~ref_clk;
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        totalChecks++;
        if (g !== e) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
        @(negedge ref_clk);
        req = '{rd: !w, wr: w, addr: a, byteEn: 4'hF, wdata: d};
        @(negedge ref_clk);
        req = '0;
        r = rsp.rdata;
        chk("ack", 32'h0000_0001, 32'(rsp.ack));
    endtask : acc
    task automatic t_run;
        for (int i = 0; i < 3; i++) begin
            acc(0, 8'h18 + 8'(4 * i), '0);
            chk("reset", '0, r);
        end
        acc(1, 8'h18, 32'hFFFF_FFFF);
        acc(0, 8'h18, '0);
        chk("comm", 32'hFFFF_FF00, r);
        chk("commOut", 32'hFFFF_FF00, ptrs.commAreaBase);
        @(negedge ref_clk);
        upd = '{valid: 1'b1, addr: 32'h1234_567F};
        @(negedge ref_clk);
        upd = '0;
        acc(1, 8'h1C, 32'hFFFF_FFFF);
        acc(0, 8'h1C, '0);
        chk("periodic", 32'h1234_5670, r);
        chk("periodicOut", 32'h1234_5670, ptrs.periodicCurrent);
        acc(1, 8'h20, 32'hA5A5_5A5B);
        acc(0, 8'h20, '0);
        chk("control", 32'hA5A5_5A5B, r);
        acc(0, 8'h40, '0);
        chk("unmapped", '0, r);
        $display("register tests done");
    endtask : t_run
    task automatic t_reset;
        acc(1, 8'h18, 32'h0123_4500);
        chk("commWr", 32'h0123_4500, ptrs.commAreaBase);
        acc(1, 8'h20, 32'h0000_1230);
        @(negedge ref_clk);
        swRst = 1;
        @(negedge ref_clk);
        swRst = 0;
        chk("swComm", '0, ptrs.commAreaBase);
        chk("swControl", '0, ptrs.controlListHead);
        chk("swPeriodic", '0, ptrs.periodicCurrent);
        acc(1, 8'h18, 32'h0000_AB00);
        @(negedge ref_clk);
        sys_rst = 1;
        repeat (2) @(negedge ref_clk);
        sys_rst = 0;
        chk("rstComm", '0, ptrs.commAreaBase);
        chk("rstAck", '0, 32'(rsp.ack));
        acc(0, 8'h18, '0);
        chk("rstRead", '0, r);
        $display("reset tests done");
    endtask : t_reset
    task automatic conclude;
        $display("checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    initial begin
        #20000;
        errorCnt++;
        conclude();
    end
    initial begin
        repeat (2) @(negedge ref_clk);
        sys_rst = 0;
        t_run();
        t_reset();
        conclude();
    end
endmodule : tb_top
